/* File: verilog/servo_velocity_limit_and_gearing.sv */
/*
 * Velocity limiter, interpolating follower and electronic gearing of a
 * servo drive, with a Wishbone register slave and the data registers.
 * Assumes synchronous inputs from the servo loop and a classic Wishbone
 * master; commands arrive as opcode and parameter words plus a go write.
 */
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "servo_defines.svh"
module servo_velocity_limit_and_gearing #(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic traj_active_i,
	input wire logic settling_i,
	input wire logic signed [15:0] vel_loop_i,
	input wire logic signed [15:0] gravity_offset_i,
	input wire logic [31:0] master_pos_i,
	output logic signed [17:0] drive_cmd_o,
	output logic vlim_engaged_o,
	output logic [31:0] target_pos_o,
	output logic [31:0] target_vel_o,
	output logic acc_ff_en_o,
	output logic servo_tick_o
);
	dreg_if dport ();
	dreg_mem u_mem (.clk_sys_i(clk_sys_i), .port(dport));

	////////////////////////////////////////////////////////////////////////
	// servo tick
	logic [15:0] tick_cnt_q, tick_cnt_d;
	logic tick_q, tick_d;
	always_comb begin
		tick_d = (tick_cnt_q == 16'(TICK_CYCLES - 1));
		tick_cnt_d = tick_d ? 16'h0000 : tick_cnt_q + 16'h0001;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end
	assign servo_tick_o = tick_q;

	////////////////////////////////////////////////////////////////////////
	// velocity limiter
	logic [15:0] mov_lim_q, hold_lim_q;
	logic signed [17:0] drive_q, drive_d;
	logic live_q, live_d;
	logic signed [16:0] lim_s, vel_s, clamp_s;
	always_comb begin
		lim_s = (traj_active_i || settling_i) ? $signed({2'b00, mov_lim_q[14:0]})
			: $signed({2'b00, hold_lim_q[14:0]});
		vel_s = 17'(vel_loop_i);
		clamp_s = vel_s;
		live_d = live_q;
		drive_d = drive_q;
		if (vel_s > lim_s) begin
			clamp_s = lim_s;
		end else if (vel_s < -lim_s) begin
			clamp_s = -lim_s;
		end
		if (tick_q) begin
			live_d = (clamp_s != vel_s);
			// gravity offset sits outside the clamp on purpose
			drive_d = 18'(clamp_s) + 18'(gravity_offset_i);
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_q <= 18'h00000;
			live_q <= 1'b0;
		end else begin
			drive_q <= drive_d;
			live_q <= live_d;
		end
	end
	assign drive_cmd_o = drive_q;
	assign vlim_engaged_o = live_q;

	////////////////////////////////////////////////////////////////////////
	// bus slave: every access answers two cycles after it is presented
	logic pend_q, ack_q, in_mem, wr_fire;
	logic [9:0] widx;
	assign widx = wb_adr_i[11:2];
	assign in_mem = widx[`DREG_WIN_BIT - 2];
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && pend_q && !ack_q;
	assign dport.bus_addr = widx[7:0];
	assign dport.bus_we = wr_fire && in_mem;
	assign dport.bus_sel = wb_sel_i;
	assign dport.bus_wdata = wb_dat_i;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// commands, mode and motion engine
	servo_pkg::motion_t mode_q, mode_d;
	servo_pkg::eng_t eng_q, eng_d;
	logic [31:0] par_q [5];
	logic [31:0] par_d [5];
	logic [15:0] mov_lim_d, hold_lim_d, stop_st_q, stop_st_d;
	logic [7:0] base_q, base_d, cnt_q, cnt_d, seg_q, seg_d, bres_q, bres_d;
	logic busy_q, busy_d, err_q, err_d, sticky_q, sticky_d, stop_en_q, stop_en_d;
	logic neg_q, neg_d;
	logic [31:0] pos_q, pos_d, vel_q, vel_d, step_q, step_d, rem_q, rem_d;
	logic [31:0] tmp_q, tmp_d, af_q, af_d, sf_q, sf_d, mprev_q, mprev_d;
	logic [47:0] num_q, num_d;
	logic [32:0] drem_q, drem_d, trial;
	logic [31:0] den_q, den_d;
	logic [5:0] dcnt_q, dcnt_d;
	logic [31:0] dat_q, dat_d;
	logic signed [32:0] delta;
	logic signed [16:0] dm;
	logic signed [49:0] prod;
	logic [31:0] adv, sf_new;
	logic [8:0] bsum;
	logic go, op_ok;

	always_comb begin
		mode_d = mode_q;
		eng_d = eng_q;
		par_d = par_q;
		mov_lim_d = mov_lim_q;
		hold_lim_d = hold_lim_q;
		stop_st_d = stop_st_q;
		stop_en_d = stop_en_q;
		base_d = base_q;
		cnt_d = cnt_q;
		seg_d = seg_q;
		bres_d = bres_q;
		busy_d = busy_q;
		err_d = err_q;
		sticky_d = sticky_q;
		neg_d = neg_q;
		pos_d = pos_q;
		vel_d = vel_q;
		step_d = step_q;
		rem_d = rem_q;
		tmp_d = tmp_q;
		af_d = af_q;
		sf_d = sf_q;
		mprev_d = mprev_q;
		num_d = num_q;
		drem_d = drem_q;
		den_d = den_q;
		dcnt_d = dcnt_q;
		dat_d = dat_q;
		dport.eng_addr = base_q;
		delta = 33'sh0;
		dm = 17'sh0;
		prod = 50'sh0;
		adv = 32'h0;
		sf_new = sf_q;
		bsum = 9'h000;
		trial = {drem_q[31:0], num_q[47]};
		go = 1'b0;
		op_ok = 1'b0;

		// register writes and reads
		if (wr_fire && !in_mem) begin
			if (widx <= `REG_CMD_P4) begin
				par_d[widx[2:0]] = merge(par_q[widx[2:0]], wb_dat_i, wb_sel_i);
			end
			go = (widx == `REG_CMD_GO) && !busy_q;
			if (widx == `REG_STATUS2 && wb_dat_i[`IS2_VLIM_BIT]) begin
				sticky_d = 1'b0;
			end
			if (widx == `REG_MODE && wb_dat_i[`MODE_ERR_BIT]) begin
				err_d = 1'b0;
			end
		end
		if (tick_q && live_q) begin
			sticky_d = 1'b1;
		end
		if (pend_q) begin
			dat_d = 32'h0;
			if (in_mem) begin
				dat_d = dport.bus_rdata;
			end else if (widx <= `REG_CMD_P4) begin
				dat_d = par_q[widx[2:0]];
			end else if (widx == `REG_STATUS2) begin
				dat_d[`IS2_VLIM_BIT] = sticky_q;
				dat_d[`IS2_LIVE_BIT] = live_q;
			end else if (widx == `REG_MODE) begin
				dat_d = {26'h0, err_q, busy_q, 1'b0, mode_q};
			end else if (widx == `REG_LIMITS) begin
				dat_d = {hold_lim_q, mov_lim_q};
			end else if (widx == `REG_STOP) begin
				dat_d = {15'h0, stop_en_q, stop_st_q};
			end
		end
		if (tick_q) begin
			busy_d = 1'b0;
		end

		// command decode
		if (go) begin
			unique case (par_q[0][7:0])
			`OP_VLIM: begin
				op_ok = !par_q[1][15] && !par_q[2][15];
				if (op_ok) begin
					mov_lim_d = par_q[1][15:0];
					hold_lim_d = par_q[2][15:0];
				end
			end
			`OP_FOLLOW: begin
				op_ok = par_q[1][15:0] == `FOLLOW_MODE_ABS
					&& par_q[2][7:0] >= `DREG_MIN && par_q[2][7:0] <= `DREG_MAX
					&& par_q[2][15:8] == 8'h00
					&& par_q[3][7:0] >= `CNT_MIN && par_q[3][7:0] <= `CNT_MAX
					&& par_q[3][15:8] == 8'h00;
				if (op_ok) begin
					mode_d = servo_pkg::M_FOLLOW;
					base_d = par_q[2][7:0];
					cnt_d = par_q[3][7:0];
					seg_d = 8'h00;
					eng_d = servo_pkg::E_IDLE;
					busy_d = 1'b1;
				end
			end
			`OP_GEAR: begin
				op_ok = par_q[2][7:0] >= `DREG_MIN && par_q[2][7:0] <= `DREG_MAX
					&& par_q[2][15:8] == 8'h00;
				if (op_ok) begin
					mode_d = servo_pkg::M_GEAR;
					base_d = par_q[2][7:0];
					stop_en_d = par_q[3][0];
					stop_st_d = par_q[4][15:0];
					mprev_d = master_pos_i;
					rem_d = 32'h0;
					neg_d = 1'b0;
					sf_d = 32'h0;
					eng_d = servo_pkg::E_IDLE;
				end
			end
			default: op_ok = 1'b0;
			endcase
			if (!op_ok) begin
				err_d = 1'b1;
			end
		end else begin
			// motion engine; the trajectory never looks at the clamp
			unique case (eng_q)
			servo_pkg::E_IDLE: begin
				if (tick_q && mode_q == servo_pkg::M_GEAR) begin
					eng_d = servo_pkg::E_RD0;
				end else if (tick_q && mode_q == servo_pkg::M_FOLLOW) begin
					eng_d = (seg_q == 8'h00) ? servo_pkg::E_RD0
						: servo_pkg::E_APPLY;
				end
			end
			servo_pkg::E_RD0: begin
				eng_d = servo_pkg::E_RD1;
			end
			servo_pkg::E_RD1: begin
				dport.eng_addr = base_q + 8'h01;
				tmp_d = dport.eng_rdata;
				eng_d = servo_pkg::E_RD2;
			end
			servo_pkg::E_RD2: begin
				dport.eng_addr = base_q + 8'h01;
				dcnt_d = 6'd47;
				drem_d = 33'h0;
				eng_d = servo_pkg::E_DIV;
				if (mode_q == servo_pkg::M_FOLLOW) begin
					vel_d = dport.eng_rdata;
					delta = $signed({tmp_q[31], tmp_q}) - $signed({pos_q[31], pos_q});
					neg_d = delta[32];
					num_d = {15'h0, neg_d ? 33'(-delta) : 33'(delta)};
					den_d = {24'h0, cnt_q};
				end else begin
					af_d = tmp_q;
					// ramp toward the new factor by at most the accel factor, or load it at once when the accel factor is zero
					if (tmp_q == 32'h0) begin
						sf_new = dport.eng_rdata;
					end else if ($signed(dport.eng_rdata) > $signed(sf_q + tmp_q)) begin
						sf_new = sf_q + tmp_q;
					end else if ($signed(dport.eng_rdata) < $signed(sf_q - tmp_q)) begin
						sf_new = sf_q - tmp_q;
					end else begin
						sf_new = dport.eng_rdata;
					end
					sf_d = sf_new;
					delta = $signed({master_pos_i[31], master_pos_i})
						- $signed({mprev_q[31], mprev_q});
					dm = (delta > 33'sh0FFFF) ? 17'sh0FFFF
						: (delta < -33'sh0FFFF) ? -17'sh0FFFF : 17'(delta);
					mprev_d = master_pos_i;
					// widen both factors first: a self-sized product overflows
					prod = 50'(dm) * 50'($signed(sf_new))
						+ (neg_q ? -$signed({18'h0, rem_q}) : $signed({18'h0, rem_q}));
					neg_d = prod[49];
					num_d = neg_d ? 48'(-prod) : 48'(prod);
					den_d = `SF_UNITY;
				end
			end
			servo_pkg::E_DIV: begin
				if (trial >= {1'b0, den_q}) begin
					drem_d = trial - {1'b0, den_q};
					num_d = {num_q[46:0], 1'b1};
				end else begin
					drem_d = trial;
					num_d = {num_q[46:0], 1'b0};
				end
				dcnt_d = dcnt_q - 6'd1;
				if (dcnt_q == 6'd0) begin
					// the last quotient bit lands this cycle, so take the _d values
					step_d = num_d[31:0];
					rem_d = drem_d[31:0];
					bres_d = 8'h00;
					seg_d = cnt_q;
					eng_d = servo_pkg::E_APPLY;
				end
			end
			servo_pkg::E_APPLY: begin
				eng_d = servo_pkg::E_IDLE;
				if (mode_q == servo_pkg::M_FOLLOW) begin
					// spread the remainder so the segment ends on target
					bsum = {1'b0, bres_q} + {1'b0, rem_q[7:0]};
					adv = step_q;
					bres_d = bsum[7:0];
					if (bsum >= {1'b0, cnt_q}) begin
						adv = step_q + 32'h1;
						bres_d = 8'(bsum - {1'b0, cnt_q});
					end
					seg_d = seg_q - 8'h01;
				end else begin
					adv = step_q;
					vel_d = neg_q ? -step_q : step_q;
				end
				pos_d = neg_q ? pos_q - adv : pos_q + adv;
			end
			default: eng_d = servo_pkg::E_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= servo_pkg::M_IDLE;
			eng_q <= servo_pkg::E_IDLE;
			for (int i = 0; i < 5; i++) begin
				par_q[i] <= 32'h0;
			end
			mov_lim_q <= `VLIM_MOV_RST;
			hold_lim_q <= `VLIM_HOLD_RST;
			{stop_st_q, stop_en_q, base_q, cnt_q, seg_q, bres_q} <= 49'h0;
			{busy_q, err_q, sticky_q, neg_q} <= 4'h0;
			{pos_q, vel_q, step_q, rem_q, tmp_q, af_q} <= 192'h0;
			{sf_q, mprev_q, den_q, dat_q} <= 128'h0;
			{num_q, drem_q, dcnt_q} <= 87'h0;
			pend_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			eng_q <= eng_d;
			par_q <= par_d;
			mov_lim_q <= mov_lim_d;
			hold_lim_q <= hold_lim_d;
			{stop_st_q, stop_en_q, base_q, cnt_q, seg_q, bres_q} <=
				{stop_st_d, stop_en_d, base_d, cnt_d, seg_d, bres_d};
			{busy_q, err_q, sticky_q, neg_q} <= {busy_d, err_d, sticky_d, neg_d};
			{pos_q, vel_q, step_q, rem_q, tmp_q, af_q} <=
				{pos_d, vel_d, step_d, rem_d, tmp_d, af_d};
			{sf_q, mprev_q, den_q, dat_q} <= {sf_d, mprev_d, den_d, dat_d};
			{num_q, drem_q, dcnt_q} <= {num_d, drem_d, dcnt_d};
			pend_q <= wb_cyc_i && wb_stb_i && !pend_q && !ack_q;
			ack_q <= wb_cyc_i && wb_stb_i && pend_q && !ack_q;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign target_pos_o = pos_q;
	assign target_vel_o = vel_q;
	assign acc_ff_en_o = (mode_q == servo_pkg::M_GEAR);

	////////////////////////////////////////////////////////////////////////
	// checks
	logic ttick;
	assign ttick = tick_q;

	tick_period_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_q |=> !tick_q [*2]) else $error("tick too frequent");
	hold_select_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_q && !traj_active_i && !settling_i && !hold_lim_q[15]
		&& vel_loop_i > $signed({1'b0, hold_lim_q[14:0]})
		|=> drive_q == 18'($past(hold_lim_q[14:0]))
		+ 18'($past(gravity_offset_i)))
		else $error("holding limit not applied");
	move_select_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_q && traj_active_i && vel_loop_i >= 16'sh0
		&& vel_loop_i <= $signed({1'b0, mov_lim_q[14:0]})
		|=> drive_q == 18'($past(vel_loop_i)) + 18'($past(gravity_offset_i)))
		else $error("moving limit clamped wrongly");
	sticky_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_q && live_q |=> sticky_q) else $error("engage flag lost");
	busy_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		busy_q && tick_q |=> !busy_q) else $error("busy outlives tick");
	follow_acc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		mode_q == servo_pkg::M_FOLLOW |-> !acc_ff_en_o)
		else $error("follower drives acceleration");
	bad_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		go && par_q[0][7:0] == `OP_FOLLOW && par_q[1][15:0] != 16'h0
		|=> err_q && $stable(mode_q)) else $error("nonzero mode accepted");
	vlim_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		go && par_q[0][7:0] == `OP_VLIM && !par_q[1][15] && !par_q[2][15]
		|=> mov_lim_q == $past(par_q[1][15:0])
		&& hold_lim_q == $past(par_q[2][15:0])) else $error("limits not set");
	seg_end_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		eng_q == servo_pkg::E_DIV && dcnt_q == 6'd0
		&& mode_q == servo_pkg::M_FOLLOW |=> seg_q == cnt_q
		##1 seg_q == cnt_q - 8'h01) else $error("segment length wrong");
	ack_once_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");

	follow_run_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		mode_q == servo_pkg::M_FOLLOW && eng_q == servo_pkg::E_APPLY);
	gear_run_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		mode_q == servo_pkg::M_GEAR && eng_q == servo_pkg::E_APPLY);
	clamp_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ttick && live_q);
	refused_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_fire && widx == `REG_CMD_GO && busy_q);
endmodule : servo_velocity_limit_and_gearing

/* File: verilog/servo_defines.svh */
/*
 * Offsets, field positions, reset values and timing counts of the servo
 * velocity limiter, follower and gearing block.
 * Assumes a 200 MHz system clock and a byte-addressed Wishbone window.
 */
`ifndef SERVO_DEFINES_SVH
`define SERVO_DEFINES_SVH

// timing
`define CLK_MHZ 200
`define TICK_NS 120000
`define TICK_CYCLES ((`TICK_NS * `CLK_MHZ) / 1000)

// register word offsets, address bits [11:2]
`define REG_CMD_OP 10'h000
`define REG_CMD_P1 10'h001
`define REG_CMD_P2 10'h002
`define REG_CMD_P3 10'h003
`define REG_CMD_P4 10'h004
`define REG_CMD_GO 10'h005
`define REG_STATUS2 10'h006
`define REG_MODE 10'h007
`define REG_LIMITS 10'h008
`define REG_STOP 10'h009
`define DREG_WIN_BIT 10

// status and mode fields
`define IS2_LIVE_BIT 0
`define IS2_VLIM_BIT 1
`define MODE_BUSY_BIT 4
`define MODE_ERR_BIT 5

// command opcodes and parameter ranges
`define OP_VLIM 8'h45
`define OP_FOLLOW 8'h5A
`define OP_GEAR 8'h5D
`define DREG_MIN 8'h0B
`define DREG_MAX 8'hC6
`define CNT_MIN 8'h01
`define CNT_MAX 8'h80
`define FOLLOW_MODE_ABS 16'h0000
`define GEAR_MODE_DEF 16'h0008
`define SF_UNITY 32'h0098_9680

// reset values
`define VLIM_MOV_RST 16'h7FFF
`define VLIM_HOLD_RST 16'h7FFF

`endif

/* File: verilog/servo_pkg.sv */
/*
 * Types of the servo velocity limiter, follower and gearing block.
 * Assumes nothing beyond the defines header.
 */
package servo_pkg;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_FOLLOW = 3'b010,
		M_GEAR = 3'b100
	} motion_t;

	typedef enum logic [5:0] {
		E_IDLE = 6'b000001,
		E_RD0 = 6'b000010,
		E_RD1 = 6'b000100,
		E_RD2 = 6'b001000,
		E_DIV = 6'b010000,
		E_APPLY = 6'b100000
	} eng_t;

endpackage : servo_pkg

/* File: verilog/dreg_if.sv */
/*
 * Connection between the servo logic and its data register memory.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface dreg_if;
	logic [7:0] bus_addr;
	logic bus_we;
	logic [3:0] bus_sel;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic [7:0] eng_addr;
	logic [31:0] eng_rdata;
	modport user (output bus_addr, bus_we, bus_sel, bus_wdata, eng_addr,
		input bus_rdata, eng_rdata);
	modport mem (input bus_addr, bus_we, bus_sel, bus_wdata, eng_addr,
		output bus_rdata, eng_rdata);
endinterface : dreg_if

/* File: verilog/dreg_mem.sv */
/*
 * Data register memory: 256 words, one byte-lane write port shared with a
 * registered read, and a second registered read port for the engine.
 * Assumes addresses are held for one cycle to get read data.
 */
`timescale 1ns/100ps
module dreg_mem (
	input wire logic clk_sys_i,
	dreg_if.mem port
);
	logic [31:0] mem_q [256];
	logic [31:0] bus_rd_q;
	logic [31:0] eng_rd_q;

	// no reset: contents are software data, read ports are registered
	always_ff @(posedge clk_sys_i) begin
		for (int b = 0; b < 4; b++) begin
			if (port.bus_we && port.bus_sel[b]) begin
				mem_q[port.bus_addr][8*b +: 8] <= port.bus_wdata[8*b +: 8];
			end
		end
		bus_rd_q <= mem_q[port.bus_addr];
		eng_rd_q <= mem_q[port.eng_addr];
	end

	assign port.bus_rdata = bus_rd_q;
	assign port.eng_rdata = eng_rd_q;
endmodule : dreg_mem

/* File: testbench/host_model.sv */
/* host side of the servo block: a classic wishbone master with
   write and read tasks for the bench to call.
   assumes the bench's clock and a slave that always acks. */
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [11:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 12'h000;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// the leading edge keeps one idle cycle between two requests
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released data must not look like the last write
		dat_o <= ~d;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask : rd
endmodule : host_model

/* File: testbench/testbench.sv */
/* self-checking bench of the velocity limiter, follower and gearing.
   assumes the host model as bus master and a 64-cycle servo tick. */
`timescale 1ns/100ps
`include "servo_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, target_pos_o, target_vel_o;
	logic traj_active_i = 1'b0;
	logic settling_i = 1'b0;
	logic signed [15:0] vel_loop_i = 16'h0000;
	logic signed [15:0] gravity_offset_i = 16'h0000;
	logic [31:0] master_pos_i = 32'h0;
	logic signed [17:0] drive_cmd_o;
	logic vlim_engaged_o, acc_ff_en_o, servo_tick_o;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] q, pos, vel, gear_d = 32'h0;
	int mov, hold, lim, v, g, n, cnt;
	time t0;
	logic [7:0] bad_op[7] = '{8'h33, 8'h45, 8'h5A, 8'h5A, 8'h5A, 8'h5A,
		8'h5D};
	int bad_p[7][3] = '{'{0, 0, 0}, '{32768, 100, 0}, '{1, 20, 1},
		'{0, 10, 1}, '{0, 20, 0}, '{0, 20, 129}, '{8, 199, 0}};

	always #2.5 clk_sys_i = ~clk_sys_i;

	servo_velocity_limit_and_gearing #(.TICK_CYCLES(64))
		servo_velocity_limit_and_gearing_i (.clk_sys_i, .rst_n_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .traj_active_i, .settling_i, .vel_loop_i,
		.gravity_offset_i, .master_pos_i, .drive_cmd_o, .vlim_engaged_o,
		.target_pos_o, .target_vel_o, .acc_ff_en_o, .servo_tick_o);

	host_model host_model_i (.clk_i(clk_sys_i), .ack_i(wb_ack_o),
		.dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
		.we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i),
		.dat_o(wb_dat_i));

	// the master axis publishes a new position once per tick
	always @(posedge clk_sys_i) begin
		if (servo_tick_o === 1'b1) begin
			master_pos_i <= master_pos_i + gear_d;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// whole servo ticks covering a master period, never fewer
	function automatic int tick_count(input int period_ns);
		return (period_ns + 119999) / 120000;
	endfunction : tick_count

	function automatic logic signed [17:0] exp_drive(input int v, l, g);
		int c;
		c = v;
		if (c > l) c = l;
		if (c < -l) c = -l;
		return 18'(c + g);
	endfunction : exp_drive

	task automatic cmd(input logic [7:0] op, input int p1, p2, p3, p4);
		int w[5];
		w = '{int'(op), p1, p2, p3, p4};
		for (int i = 0; i < 5; i++) begin
			host_model_i.wr(12'(4 * i), 32'(w[i]));
		end
		host_model_i.wr(12'h014, 32'h0);
	endtask : cmd

	task automatic wait_ticks(input int k);
		repeat (k) do @(posedge clk_sys_i); while (servo_tick_o !== 1'b1);
	endtask : wait_ticks

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(67));
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		host_model_i.rd(12'h020, q);
		`CHK("limits at reset", 32'h7FFF7FFF, q)
		host_model_i.wr(12'h028, 32'hFFFFFFFF);
		host_model_i.rd(12'h028, q);
		`CHK("unmapped read", 32'h0, q)
		wait_ticks(1);
		t0 = $time;
		wait_ticks(1);
		`CHK("tick period", 64, ($time - t0) / 5)
		for (int i = 0; i < 7; i++) begin
			host_model_i.wr(12'h01C, 32'h20);
			cmd(bad_op[i], bad_p[i][0], bad_p[i][1], bad_p[i][2], 0);
			host_model_i.rd(12'h01C, q);
			`CHK("frame refused", 1'b1, q[5])
		end
		host_model_i.wr(12'h01C, 32'h20);
		for (int i = 0; i < 8; i++) begin
			mov = 455 + $urandom % 32313;
			hold = (i == 0) ? 32767 : 455 + $urandom % 32313;
			v = $signed(16'($urandom));
			g = $signed(16'($urandom));
			traj_active_i <= i[0];
			settling_i <= i[1];
			vel_loop_i <= 16'(v);
			gravity_offset_i <= 16'(g);
			cmd(8'h45, mov, hold, 0, 0);
			host_model_i.rd(12'h020, q);
			`CHK("limits", {16'(hold), 16'(mov)}, q)
			lim = (i[1:0] != 2'b00) ? mov : hold;
			wait_ticks(2);
			@(posedge clk_sys_i);
			@(negedge clk_sys_i);
			`CHK("drive", exp_drive(v, lim, g), drive_cmd_o)
			`CHK("engaged", (v > lim || v < -lim), vlim_engaged_o)
			if (v > lim || v < -lim) begin
				host_model_i.rd(12'h018, q);
				`CHK("sticky clamp", 1'b1, q[1])
				host_model_i.wr(12'h018, 32'h2);
				host_model_i.rd(12'h018, q);
				`CHK("sticky clear", 2'b01, q[1:0])
			end
		end
		n = 11 + $urandom % 188;
		pos = $urandom;
		vel = $urandom;
		cnt = tick_count(120000 + $urandom % 360000);
		host_model_i.wr(12'(32'h400 + 4 * n), pos);
		host_model_i.wr(12'(32'h400 + 4 * n + 4), vel);
		wait_ticks(1);
		cmd(8'h5A, 0, n, cnt, 0);
		host_model_i.rd(12'h01C, q);
		`CHK("follow busy", 6'h12, q[5:0])
		wait_ticks(cnt + 3);
		`CHK("follow pos", pos, target_pos_o)
		`CHK("follow vel", vel, target_vel_o)
		`CHK("follow accel", 1'b0, acc_ff_en_o)
		host_model_i.rd(12'h01C, q);
		`CHK("follow modal", 6'h02, q[5:0])
		n = 11 + $urandom % 188;
		host_model_i.wr(12'(32'h400 + 4 * n), 32'h0);
		for (int k = 1; k < 4; k++) begin
			gear_d <= 1 + $urandom % 1000;
			host_model_i.wr(12'(32'h400 + 4 * n + 4), 32'(k * 10000000));
			if (k == 1) cmd(8'h5D, 8, n, 0, 0);
			wait_ticks(4);
			`CHK("gear step", 32'(k * gear_d), target_vel_o)
			`CHK("gear accel", 1'b1, acc_ff_en_o)
		end
		host_model_i.rd(12'h01C, q);
		`CHK("gear mode", 3'b100, q[2:0])
		end_of_test();
	end
endmodule : testbench
